/* verilog/lcc_cells.sv */
// The implementer's own choice: the strobed register port.
`default_nettype none
module lcc_cells (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [11:0] CELL_PIN_IN,
    input  wire logic [3:0]  EVENT_A,
    input  wire logic [3:0]  EVENT_B,
    input  wire logic        CMP_OUT,
    input  wire logic [2:0]  SERIAL_TX,
    input  wire logic        SPI_MOSI,
    input  wire logic        SPI_SCK,
    input  wire logic [2:0]  TIMER_A_CMP,
    input  wire logic [2:0]  TIMER_B_OUT,
    input  wire logic        FAST_OSC,
    input  wire logic        SLOW_OSC,
    output logic      [3:0]  CELL_OUT,
    output logic      [3:0]  CELL_PIN_OUT,
    output logic      [3:0]  CELL_PIN_OE_N
);

    ////////////////////////////////////////////////////////////////////////////
    // Input routing shared by all three inputs of every cell.
    function automatic logic lcc_pick(
        input logic [3:0] code,
        input logic [1:0] k,
        input logic       fb,
        input logic       link,
        input logic       eva,
        input logic       evb,
        input logic       pin,
        input logic       cmp
    );
        case (code)
            lcc_pkg::LCC_IN_MASK: lcc_pick = 1'b0;                            // R8
            lcc_pkg::LCC_IN_FB:   lcc_pick = fb;                              // R8
            lcc_pkg::LCC_IN_LINK: lcc_pick = link;                            // R8
            lcc_pkg::LCC_IN_EVA:  lcc_pick = eva;
            lcc_pkg::LCC_IN_EVB:  lcc_pick = evb;
            lcc_pkg::LCC_IN_PIN:  lcc_pick = pin;
            lcc_pkg::LCC_IN_CMP:  lcc_pick = cmp;                             // R9
            lcc_pkg::LCC_IN_SER:  lcc_pick = SERIAL_TX[k];                    // R10
            lcc_pkg::LCC_IN_SPI:  lcc_pick = (k == 2'd2) ? SPI_SCK : SPI_MOSI; // R11
            lcc_pkg::LCC_IN_TCA:  lcc_pick = TIMER_A_CMP[k];                  // R9
            lcc_pkg::LCC_IN_TCB:  lcc_pick = TIMER_B_OUT[k];                  // R10
            default:              lcc_pick = 1'b0;
        endcase
    endfunction : lcc_pick

    // Clock enable of a cell; reserved codes never tick, so its filter and edge registers hold.
    function automatic logic lcc_clk_en(
        input logic [2:0] src,
        input logic       in2_rise,
        input logic       fast_rise,
        input logic       slow_rise,
        input logic       k1
    );
        case (src)
            lcc_pkg::LCC_PERIPHERAL_CLOCK:  lcc_clk_en = 1'b1;      // R4
            lcc_pkg::LCC_CLK_IN2:  lcc_clk_en = in2_rise;  // R4
            lcc_pkg::LCC_CLK_FAST: lcc_clk_en = fast_rise; // R5
            lcc_pkg::LCC_CLK_32K:  lcc_clk_en = slow_rise; // R5
            lcc_pkg::LCC_CLK_1K:   lcc_clk_en = k1;        // R5
            default:               lcc_clk_en = 1'b0;
        endcase
    endfunction : lcc_clk_en

    // Byte address of one register of cell i.
    function automatic logic [7:0] lcc_ofs(input logic [7:0] base, input int i);
        lcc_ofs = base + lcc_pkg::LCC_STRIDE * 8'(i);
    endfunction : lcc_ofs

    ////////////////////////////////////////////////////////////////////////////
    lcc_pkg::lcc_state_s s_q;
    lcc_pkg::lcc_state_s s_d;
    logic [3:0][2:0]     idx;
    logic [3:0]          lut;
    logic [3:0]          ce;
    logic [3:0]          act;
    logic [3:0]          f_v;
    logic [3:0]          e_v;
    logic [3:0]          v_v;
    logic                fast_rise;
    logic                slow_rise;

    // Next state of the whole block.
    always_comb begin
        s_d = s_q;
        idx = '0;
        lut = '0;
        ce = '0;
        act = '0;
        f_v = '0;
        e_v = '0;
        v_v = '0;
        s_d.rdata = 8'h00;
        // Oscillators and pins come from other domains, so only the second stage is read.
        s_d.s1 = {SLOW_OSC, FAST_OSC, CMP_OUT, CELL_PIN_IN};
        s_d.s2 = s_q.s1;
        s_d.oprev = s_q.s2[14:13];
        // The fast oscillator outruns this clock; edges are only seen when it is slowed externally.
        fast_rise = s_q.s2[13] & ~s_q.oprev[0];
        slow_rise = s_q.s2[14] & ~s_q.oprev[1];
        s_d.k1 = 1'b0;
        if (slow_rise) begin
            s_d.div = s_q.div + 5'h01;
            s_d.k1 = (s_q.div == lcc_pkg::LCC_DIV_LAST); // R5
        end

        // Register writes; protected ones are dropped while the peripheral runs.
        if (WR) begin
            if (ADDR == lcc_pkg::LCC_GCTRL_OFS) begin
                s_d.glob_en = WDATA[0];
            end
            if (!s_q.glob_en) begin // R17
                if (ADDR == lcc_pkg::LCC_SEQ0_OFS) begin
                    s_d.seqsel[0] = WDATA[3:0];
                end
                if (ADDR == lcc_pkg::LCC_SEQ1_OFS) begin
                    s_d.seqsel[1] = WDATA[3:0];
                end
                for (int i = 0; i < 4; i++) begin
                    if (ADDR == lcc_ofs(lcc_pkg::LCC_CTRLA_OFS, i)) begin
                        s_d.ctrl[i] = WDATA;
                    end
                    if (ADDR == lcc_ofs(lcc_pkg::LCC_SELLO_OFS, i)) begin
                        s_d.sello[i] = WDATA;
                    end
                    if (ADDR == lcc_ofs(lcc_pkg::LCC_SELHI_OFS, i)) begin
                        s_d.selhi[i] = WDATA[3:0];
                    end
                    if (ADDR == lcc_ofs(lcc_pkg::LCC_PAT_OFS, i)) begin
                        s_d.pat[i] = WDATA;
                    end
                end
            end
        end

        // Register reads; unmapped addresses answer zero.
        if (RD) begin
            if (ADDR == lcc_pkg::LCC_GCTRL_OFS) begin
                s_d.rdata = {7'h00, s_q.glob_en};
            end
            if (ADDR == lcc_pkg::LCC_SEQ0_OFS) begin
                s_d.rdata = {4'h0, s_q.seqsel[0]};
            end
            if (ADDR == lcc_pkg::LCC_SEQ1_OFS) begin
                s_d.rdata = {4'h0, s_q.seqsel[1]};
            end
            for (int i = 0; i < 4; i++) begin
                if (ADDR == lcc_ofs(lcc_pkg::LCC_CTRLA_OFS, i)) begin
                    s_d.rdata = s_q.ctrl[i];
                end
                if (ADDR == lcc_ofs(lcc_pkg::LCC_SELLO_OFS, i)) begin
                    s_d.rdata = s_q.sello[i];
                end
                if (ADDR == lcc_ofs(lcc_pkg::LCC_SELHI_OFS, i)) begin
                    s_d.rdata = {4'h0, s_q.selhi[i]};
                end
                if (ADDR == lcc_ofs(lcc_pkg::LCC_PAT_OFS, i)) begin
                    s_d.rdata = s_q.pat[i];
                end
            end
        end

        // Per cell: routing, pattern, clock, filter and edge detector.
        for (int i = 0; i < 4; i++) begin
            act[i] = s_q.glob_en & s_q.ctrl[i][lcc_pkg::LCC_EN_BIT]; // R7
            // Feedback and link use registered results, which keeps loops out of the routing.
            idx[i][0] = lcc_pick(s_q.sello[i][3:0], 2'd0, s_q.res[i], s_q.res[(i + 1) % 4],
                                 EVENT_A[i], EVENT_B[i], s_q.s2[3 * i], s_q.s2[12]);     // R10
            idx[i][1] = lcc_pick(s_q.sello[i][7:4], 2'd1, s_q.res[i], s_q.res[(i + 1) % 4],
                                 EVENT_A[i], EVENT_B[i], s_q.s2[3 * i + 1], s_q.s2[12]); // R9
            idx[i][2] = lcc_pick(s_q.selhi[i], 2'd2, s_q.res[i], s_q.res[(i + 1) % 4],
                                 EVENT_A[i], EVENT_B[i], s_q.s2[3 * i + 2], s_q.s2[12]); // R11
            lut[i] = s_q.pat[i][idx[i]]; // R14 R16
            ce[i] = lcc_clk_en(s_q.ctrl[i][lcc_pkg::LCC_CLK_LSB +: 3], idx[i][2] & ~s_q.in2prev[i],
                               fast_rise, slow_rise, s_q.k1); // R4
            s_d.in2prev[i] = idx[i][2];
            if (ce[i]) begin
                s_d.sh[i] = {s_q.sh[i][0], lut[i]};
                // The full filter only passes a level seen on three cell clocks in a row.
                if (s_q.sh[i][0] == lut[i] && s_q.sh[i][1] == lut[i]) begin
                    s_d.filt[i] = lut[i];
                end
            end
            case (s_q.ctrl[i][lcc_pkg::LCC_FILT_LSB +: 2])
                lcc_pkg::LCC_FILT_OFF:  f_v[i] = lut[i];       // R3
                lcc_pkg::LCC_FILT_SYNC: f_v[i] = s_q.sh[i][1]; // R3
                lcc_pkg::LCC_FILT_FULL: f_v[i] = s_q.filt[i];  // R3
                default:                f_v[i] = lut[i];
            endcase
            // Rising edge detector, one cell clock wide.
            e_v[i] = s_q.ctrl[i][lcc_pkg::LCC_EDGE_BIT] ? (f_v[i] & ~s_q.eprev[i]) : f_v[i]; // R1
            if (ce[i]) begin
                s_d.eprev[i] = f_v[i];
            end
            v_v[i] = e_v[i];
        end

        // Pair sequencers; the two flip-flop modes run on the even cell's clock, the two latches on none.
        for (int p = 0; p < 2; p++) begin
            case (s_q.seqsel[p])
                lcc_pkg::LCC_SEQ_DFF: begin
                    if (ce[2 * p]) begin // R6
                        s_d.seq[p] = e_v[2 * p];
                    end
                end
                lcc_pkg::LCC_SEQ_JK: begin
                    if (ce[2 * p]) begin // R6
                        case ({e_v[2 * p], e_v[2 * p + 1]})
                            2'b10:   s_d.seq[p] = 1'b1;
                            2'b01:   s_d.seq[p] = 1'b0;
                            2'b11:   s_d.seq[p] = ~s_q.seq[p];
                            default: s_d.seq[p] = s_q.seq[p];
                        endcase
                    end
                end
                lcc_pkg::LCC_SEQ_DL: begin
                    if (e_v[2 * p + 1]) begin
                        s_d.seq[p] = e_v[2 * p];
                    end
                end
                lcc_pkg::LCC_SEQ_RS: begin
                    if (e_v[2 * p]) begin
                        s_d.seq[p] = 1'b1;
                    end else if (e_v[2 * p + 1]) begin
                        s_d.seq[p] = 1'b0;
                    end
                end
                default: begin
                    s_d.seq[p] = s_q.seq[p];
                end
            endcase
            // Reserved codes behave as a disabled sequencer.
            if (s_q.seqsel[p] != lcc_pkg::LCC_SEQ_OFF && s_q.seqsel[p] <= lcc_pkg::LCC_SEQ_RS) begin // R15
                v_v[2 * p] = s_q.seq[p];
            end
        end

        // Results and pin drive; a disabled cell shows zero and releases its pin.
        for (int i = 0; i < 4; i++) begin
            s_d.res[i] = act[i] & v_v[i];                                           // R7
            s_d.oe_n[i] = ~(act[i] & s_q.ctrl[i][lcc_pkg::LCC_PIN_OUTPUT_ENABLE_BIT]);          // R2
        end
    end

    // State register.
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_q <= lcc_pkg::LCC_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from flip-flops.
    assign RDATA = s_q.rdata;
    assign CELL_OUT = s_q.res;
    assign CELL_PIN_OUT = s_q.res; // R2
    assign CELL_PIN_OE_N = s_q.oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Cell 3 is the one taken through its filter and edge settings, so these checks watch it.
    logic cfg3_plain;
    logic cfg3_sync;
    logic cfg3_edge;
    assign cfg3_plain = act[3] && s_q.ctrl[3][7:1] == 7'h00 && s_q.seqsel[1] == lcc_pkg::LCC_SEQ_OFF;
    assign cfg3_sync = act[3] && s_q.ctrl[3][7:1] == 7'h08 && s_q.seqsel[1] == lcc_pkg::LCC_SEQ_OFF;
    assign cfg3_edge = act[3] && s_q.ctrl[3][7:1] == 7'h40 && s_q.seqsel[1] == lcc_pkg::LCC_SEQ_OFF;

    a_disabled_zero: assert property (1'b1 |=> (CELL_OUT & ~$past(act)) == 4'h0) // R7
        else $error("disabled cell shows a one");
    a_pin_drive: assert property (1'b1 |=> CELL_PIN_OE_N[0] == !($past(act[0]) && $past(s_q.ctrl[0][6]))) // R2
        else $error("pin enable of cell 0 wrong");
    a_write_locked: assert property (WR && s_q.glob_en |=> $stable(s_q.pat) && $stable(s_q.ctrl) // R17
                                     && $stable(s_q.seqsel))
        else $error("protected write taken while enabled");
    a_pattern_lookup: assert property (cfg3_plain |=> CELL_OUT[3] == $past(s_q.pat[3][idx[3]])) // R14
        else $error("cell 3 result does not match pattern");
    a_sync_delay: assert property (cfg3_sync [*4] |-> CELL_OUT[3] == $past(lut[3], 3)) // R3
        else $error("synchronizer delay wrong");
    a_slow_divider: assert property (s_q.k1 |-> $past(slow_rise) && $past(s_q.div) == lcc_pkg::LCC_DIV_LAST) // R5
        else $error("divided clock pulse without 32 slow edges");
    a_edge_pulse: assert property ((cfg3_edge && CELL_OUT[3]) ##1 cfg3_edge |-> !CELL_OUT[3]) // R1
        else $error("edge detector output held");
    a_seq_even_clock: assert property (s_q.seqsel[0] == lcc_pkg::LCC_SEQ_DFF && !ce[0] |=> $stable(s_q.seq[0])) // R6
        else $error("sequencer moved without even cell clock");

    c_cell_on: cover property (act[0] && CELL_OUT[0]);
    c_sync_path: cover property (cfg3_sync [*4]);
    c_seq_jk: cover property (s_q.seqsel[1] == lcc_pkg::LCC_SEQ_JK && ce[2]);
    c_slow_tick: cover property (s_q.k1);

endmodule : lcc_cells
`default_nettype wire

/* include/lcc_pkg.sv */
// Behaviour
// R1: Bit 7 of the cell control register turns the edge detector on the cell output on, and 0 bypasses it.
// R2: With the pin-output enable bit set the cell result drives its own pin, overriding the port setup; cleared, nothing reaches the pin.
// R3: The filter field in bits 5:4 picks no filter, a synchronizer only or a full filter, and the fourth code is reserved.
// R4: The clock-source field picks the peripheral clock for code 0x0 and cell input 2 for 0x1; 0x2, 0x3 and 0x7 are reserved.
// R5: Clock-source 0x4 is the fast oscillator, 0x5 the 32.768 kHz oscillator and 0x6 that oscillator divided by 32.
// R6: A pair's sequencer is clocked by the clock chosen in the even cell, whatever the odd cell chooses.
// R7: A cell is active only while its enable bit 0 is set, and held off while it is clear.
// R8: Input codes 0x0 mask, 0x1 feedback, 0x2 next cell output, 0x3 event A, 0x4 event B, 0x5 own pin.
// R9: Input 1 takes comparator 0x6, serial port 1 0x8, SPI MOSI 0x9, timer A compare 1 0xA, timer B1 0xC; rest reserved.
// R10: Input 0 takes comparator 0x6, serial port 0 0x8, SPI MOSI 0x9, timer A compare 0 0xA, timer B0 0xC; rest reserved.
// R11: Input 2 takes comparator 0x6, serial port 2 0x8, SPI SCK 0x9, timer A compare 2 0xA, timer B2 0xC; rest reserved.
// R12: Software uses SPI signals as inputs only while that SPI unit is master.
// R13: Software uses serial transmit signals only in asynchronous or synchronous master mode.
// R14: The cell output is read from an eight-bit pattern, one bit per combination of the three inputs.
// R15: Pair sequencer codes are 0x0 off, 0x1 D flip-flop, 0x2 JK flip-flop, 0x3 D latch, 0x4 RS latch; rest reserved.
// R16: The pattern index has input 2 as its top bit and input 0 as its bottom bit, masked inputs reading zero.
// R17: Writes to protected cell and sequencer registers are taken only while the peripheral is disabled.
`default_nettype none
package lcc_pkg;
    // Register offsets.
    localparam logic [7:0] LCC_GCTRL_OFS  = 8'h00;
    localparam logic [7:0] LCC_SEQ0_OFS   = 8'h01;
    localparam logic [7:0] LCC_SEQ1_OFS   = 8'h02;
    localparam logic [7:0] LCC_CTRLA_OFS  = 8'h08;
    localparam logic [7:0] LCC_SELLO_OFS  = 8'h09;
    localparam logic [7:0] LCC_SELHI_OFS  = 8'h0A;
    localparam logic [7:0] LCC_PAT_OFS    = 8'h0B;
    localparam logic [7:0] LCC_STRIDE     = 8'h04;
    localparam logic [7:0] LCC_REG_RST    = 8'h00;
    // Field positions inside the cell control register.
    localparam int LCC_EDGE_BIT  = 7;
    localparam int LCC_PIN_OUTPUT_ENABLE_BIT = 6;
    localparam int LCC_FILT_LSB  = 4;
    localparam int LCC_CLK_LSB   = 1;
    localparam int LCC_EN_BIT    = 0;
    // Filter codes.
    localparam logic [1:0] LCC_FILT_OFF  = 2'h0;
    localparam logic [1:0] LCC_FILT_SYNC = 2'h1;
    localparam logic [1:0] LCC_FILT_FULL = 2'h2;
    // Cell clock source codes.
    localparam logic [2:0] LCC_PERIPHERAL_CLOCK  = 3'h0;
    localparam logic [2:0] LCC_CLK_IN2  = 3'h1;
    localparam logic [2:0] LCC_CLK_FAST = 3'h4;
    localparam logic [2:0] LCC_CLK_32K  = 3'h5;
    localparam logic [2:0] LCC_CLK_1K   = 3'h6;
    localparam logic [4:0] LCC_DIV_LAST = 5'h1F;
    // Input source codes.
    localparam logic [3:0] LCC_IN_MASK = 4'h0;
    localparam logic [3:0] LCC_IN_FB   = 4'h1;
    localparam logic [3:0] LCC_IN_LINK = 4'h2;
    localparam logic [3:0] LCC_IN_EVA  = 4'h3;
    localparam logic [3:0] LCC_IN_EVB  = 4'h4;
    localparam logic [3:0] LCC_IN_PIN  = 4'h5;
    localparam logic [3:0] LCC_IN_CMP  = 4'h6;
    localparam logic [3:0] LCC_IN_SER  = 4'h8;
    localparam logic [3:0] LCC_IN_SPI  = 4'h9;
    localparam logic [3:0] LCC_IN_TCA  = 4'hA;
    localparam logic [3:0] LCC_IN_TCB  = 4'hC;
    // Sequencer codes.
    localparam logic [3:0] LCC_SEQ_OFF = 4'h0;
    localparam logic [3:0] LCC_SEQ_DFF = 4'h1;
    localparam logic [3:0] LCC_SEQ_JK  = 4'h2;
    localparam logic [3:0] LCC_SEQ_DL  = 4'h3;
    localparam logic [3:0] LCC_SEQ_RS  = 4'h4;

    // Whole state of the block; sync bits are pins [11:0], comparator 12, fast 13, slow 14.
    typedef struct packed {
        logic                 glob_en;
        logic [1:0][3:0]      seqsel;
        logic [3:0][7:0]      ctrl;
        logic [3:0][7:0]      sello;
        logic [3:0][3:0]      selhi;
        logic [3:0][7:0]      pat;
        logic [7:0]           rdata;
        logic [14:0]          s1;
        logic [14:0]          s2;
        logic [1:0]           oprev;
        logic [4:0]           div;
        logic                 k1;
        logic [3:0][1:0]      sh;
        logic [3:0]           filt;
        logic [3:0]           eprev;
        logic [3:0]           in2prev;
        logic [3:0]           res;
        logic [3:0]           oe_n;
        logic [1:0]           seq;
    } lcc_state_s;

    localparam lcc_state_s LCC_STATE_RST = '{oe_n: 4'hF, default: '0};
endpackage : lcc_pkg
`default_nettype wire

/* bench/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [31:0] srcv;
    logic [11:0] pin_in;
    logic [3:0]  ev_a;
    logic [3:0]  ev_b;
    logic        cmp;
    logic [2:0]  ser;
    logic        mosi;
    logic        sck;
    logic [2:0]  tca;
    logic [2:0]  tcb;
    logic        fosc;
    logic        sosc;
    logic [3:0]  cell_out;
    logic [3:0]  pin_out;
    logic [3:0]  oe_n;
    int          n_fail;
    int          checks;
    int          seed;

    ////////////////////////////////////////////////////////////////////////////////
    // All routable sources come from one vector, so a single assignment changes them together.
    assign {pin_in, ev_a, ev_b, cmp, ser, mosi, sck, tca, tcb} = srcv;

    lcc_cells dut (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CELL_PIN_IN(pin_in), .EVENT_A(ev_a), .EVENT_B(ev_b), .CMP_OUT(cmp), .SERIAL_TX(ser),
        .SPI_MOSI(mosi), .SPI_SCK(sck), .TIMER_A_CMP(tca), .TIMER_B_OUT(tcb),
        .FAST_OSC(fosc), .SLOW_OSC(sosc),
        .CELL_OUT(cell_out), .CELL_PIN_OUT(pin_out), .CELL_PIN_OE_N(oe_n)
    );

    // Free-running system clock of 100 ns.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waits whole cycles, then steps off the edge so that outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #10;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so they are looked at there.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #10;
        check(what, exp, rdata);
    endtask : rd_chk

    // Protected registers only take writes with the block stopped, so each setup stops it first.
    task automatic cfg(input int n, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] pt,
                       input logic [7:0] c);
        logic [7:0] b;
        b = lcc_pkg::LCC_CTRLA_OFS + 8'(4 * n);
        wr_reg(lcc_pkg::LCC_GCTRL_OFS, 8'h00);
        wr_reg(b, c);
        wr_reg(b + 8'h01, lo);
        wr_reg(b + 8'h02, hi);
        wr_reg(b + 8'h03, pt);
        wr_reg(lcc_pkg::LCC_GCTRL_OFS, 8'h01);
    endtask : cfg

    // Model of the input routing: bit of the source vector for a code, or -1 for mask, feedback, link and reserved.
    function automatic int src_bit(input int n, input int k, input logic [3:0] code);
        case (code)
            4'h3: return 16 + n;
            4'h4: return 12 + n;
            4'h5: return 20 + 3 * n + k;
            4'h6: return 11;
            4'h8: return 8 + k;
            4'h9: return (k == 2) ? 6 : 7;
            4'hA: return 3 + k;
            4'hC: return k;
            default: return -1;
        endcase
    endfunction : src_bit

    // Drives cell 3 input 0 high for a number of cycles and counts the cycles its output is high.
    task automatic run_in(input int width, input int win, output int cnt, output int first);
        cnt   = 0;
        first = -1;
        srcv[19] <= 1'b0;
        tick(6);
        for (int i = 0; i < win; i++) begin
            srcv[19] <= (i < width);
            tick(1);
            if (cell_out[3] === 1'b1) begin
                cnt++;
                if (first < 0) first = i;
            end
        end
        srcv[19] <= 1'b0;
        tick(6);
    endtask : run_in

    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; every loop is bounded, so the run cannot hang.
    initial begin
        logic [31:0] r;
        logic [7:0]  base;
        logic [7:0]  pt;
        int          sb;
        int          cnt;
        int          d_off;
        int          d_syn;
        seed   = 55127;
        n_fail = 0;
        checks = 0;
        rst    = 1'b1;
        addr   = 8'h00;
        wdata  = 8'h00;
        wr     = 1'b0;
        rd     = 1'b0;
        srcv   = 32'h0000_0000;
        fosc   = 1'b0;
        sosc   = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        check("pin enables after reset", 8'h0F, {4'h0, oe_n});
        for (int a = 0; a < 24; a++) rd_chk(8'(a), 8'h00, "reset value");
        rd_chk(8'h40, 8'h00, "unmapped read");
        // Read back random settings; the upper half of the high selector is not stored.
        for (int n = 0; n < 4; n++) begin
            r    = $random(seed);
            base = lcc_pkg::LCC_SELLO_OFS + 8'(4 * n);
            wr_reg(base, r[7:0]);
            wr_reg(base + 8'h01, r[15:8]);
            wr_reg(base + 8'h02, r[23:16]);
            rd_chk(base, r[7:0], "input select low");
            rd_chk(base + 8'h01, {4'h0, r[11:8]}, "input select high");
            rd_chk(base + 8'h02, r[23:16], "pattern");
        end
        wr_reg(lcc_pkg::LCC_GCTRL_OFS, 8'h01);
        wr_reg(base + 8'h02, ~r[23:16]);
        rd_chk(base + 8'h02, r[23:16], "protected pattern");
        // Every source code but feedback and link on every input of cell 1, with the other sources random.
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 16; c++) begin
                if (c == 1 || c == 2) continue;
                cfg(1, (k == 0) ? 8'(c) : (k == 1) ? 8'(c << 4) : 8'h00, (k == 2) ? 8'(c) : 8'h00,
                    (k == 0) ? 8'hAA : (k == 1) ? 8'hCC : 8'hF0, 8'h01);
                for (int v = 0; v < 2; v++) begin
                    r  = $random(seed);
                    sb = src_bit(1, k, 4'(c));
                    if (sb >= 0) r[sb] = v[0];
                    srcv <= r;
                    tick(6);
                    check("routed input", {7'h0, (sb >= 0) & v[0]}, {7'h0, cell_out[1]});
                end
            end
        end
        // Whole pattern on cell 2 with its pin driven.
        pt = 8'($random(seed));
        cfg(2, 8'h43, 8'h0C, pt, 8'h41);
        for (int i = 0; i < 8; i++) begin
            r     = $random(seed);
            r[18] = i[0];
            r[14] = i[1];
            r[2]  = i[2];
            srcv <= r;
            tick(4);
            check("pattern output", {7'h0, pt[i]}, {7'h0, cell_out[2]});
            check("pin output", {7'h0, pt[i]}, {7'h0, pin_out[2]});
            check("pin enable on", 8'h00, {7'h0, oe_n[2]});
        end
        cfg(2, 8'h43, 8'h0C, 8'hFF, 8'h01);
        tick(4);
        check("pin enable off", 8'h01, {7'h0, oe_n[2]});
        check("active output", 8'h01, {7'h0, cell_out[2]});
        cfg(2, 8'h43, 8'h0C, 8'hFF, 8'h40);
        tick(4);
        check("disabled output", 8'h00, {7'h0, cell_out[2]});
        check("disabled pin enable", 8'h01, {7'h0, oe_n[2]});
        // Filter and edge options on cell 3.
        cfg(3, 8'h03, 8'h00, 8'hAA, 8'h01);
        run_in(1, 8, cnt, d_off);
        check("unfiltered pulse", 8'h01, 8'(cnt));
        run_in(8, 8, cnt, d_off);
        cfg(3, 8'h03, 8'h00, 8'hAA, 8'h11);
        run_in(8, 8, cnt, d_syn);
        check("synchronizer delay", 8'h02, 8'(d_syn - d_off));
        cfg(3, 8'h03, 8'h00, 8'hAA, 8'h21);
        run_in(2, 10, cnt, d_syn);
        check("filtered pulse", 8'h00, 8'(cnt));
        cfg(3, 8'h03, 8'h00, 8'hAA, 8'h81);
        run_in(10, 10, cnt, d_syn);
        check("edge pulse", 8'h01, 8'(cnt));
        // Cell 0 on its input-2 clock, then the fast oscillator; the synchronizer holds it between clocks.
        srcv <= 32'h0000_0000;
        cfg(0, 8'h03, 8'h04, 8'hAA, 8'h11);
        tick(4);
        cfg(0, 8'h03, 8'h04, 8'hAA, 8'h13);
        srcv[16] <= 1'b1;
        tick(6);
        check("no input-2 tick", 8'h00, {7'h0, cell_out[0]});
        for (int i = 0; i < 2; i++) begin
            srcv[12] <= 1'b1;
            tick(3);
            srcv[12] <= 1'b0;
            tick(3);
        end
        check("input-2 tick", 8'h01, {7'h0, cell_out[0]});
        cfg(0, 8'h03, 8'h00, 8'hAA, 8'h19);
        srcv[16] <= 1'b0;
        tick(6);
        check("no oscillator tick", 8'h01, {7'h0, cell_out[0]});
        for (int i = 0; i < 3; i++) begin
            fosc <= 1'b1;
            tick(4);
            fosc <= 1'b0;
            tick(4);
        end
        check("oscillator tick", 8'h00, {7'h0, cell_out[0]});
        // Pair 0 as a D flip-flop, moved only by the even cell's clock.
        srcv <= 32'h0000_0000;
        wr_reg(lcc_pkg::LCC_GCTRL_OFS, 8'h00);
        wr_reg(lcc_pkg::LCC_SEQ0_OFS, 8'h01);
        cfg(0, 8'h03, 8'h04, 8'hAA, 8'h03);
        srcv[16] <= 1'b1;
        tick(6);
        check("seq hold", 8'h00, {7'h0, cell_out[0]});
        srcv[12] <= 1'b1;
        tick(6);
        check("seq clocked", 8'h01, {7'h0, cell_out[0]});
        // Cell 2 on the divided slow clock needs two ticks, 64 slow edges.
        cfg(2, 8'h03, 8'h00, 8'hAA, 8'h1D);
        for (int i = 0; i < 64; i++) begin
            if (i == 63) check("before 1k tick", 8'h01, {7'h0, cell_out[2]});
            sosc <= 1'b1;
            tick(3);
            sosc <= 1'b0;
            tick(3);
        end
        check("1k tick", 8'h00, {7'h0, cell_out[2]});
        conclude();
    end
endmodule : tb_top
`default_nettype wire
